/* rtl/rpc_defs.svh */
`ifndef RPC_DEFS_SVH
`define RPC_DEFS_SVH
// ****************************************
// Control and status fields
// ****************************************
`define RPC_CC_OUT_LSB 0
`define RPC_CC_OUT_MSB 2
`define RPC_CC_HZ50 3
`define RPC_CC_XSEL_LSB 4
`define RPC_CC_XSEL_MSB 5
`define RPC_CC_LINE 6
`define RPC_IC_PSEL_LSB 0
`define RPC_IC_PSEL_MSB 3
`define RPC_IC_ALARM 4
`define RPC_IC_PSENSE 5
`define RPC_IC_PWRDN 6
`define RPC_IC_WDOG 7
`define RPC_ST_CLK 0
`define RPC_ST_ALM 1
`define RPC_ST_PFAIL 2
`define RPC_ST_INT 3
`define RPC_ST_FTU 4
`define RPC_ST_WD 6
// ****************************************
// Reset values and masks
// ****************************************
`define RPC_CTRL_RST 8'h00
`define RPC_STAT_RST 8'h10
`define RPC_STAT_KEEP 8'h04
`define RPC_OUT_OFF 3'h4
// ****************************************
// Timing
// ****************************************
`define RPC_CLK_MHZ 125
`define RPC_ALM_US_4M 7600
`define RPC_ALM_US_2M 15300
`define RPC_ALM_US_SLOW 30500
`define RPC_WD_SVC_TICKS 2
`define RPC_WD_DLY_TICKS 2
`define RPC_WD_RST_TICKS 2
`endif

/* rtl/rpc_pkg.sv */
`default_nettype none
package rpc_pkg;
    typedef enum logic [1:0] {
        PWR_OFF = 2'b00,
        PWR_ON = 2'b01,
        PWR_DOWN = 2'b10
    } rpc_pwr_e;
    typedef enum logic [1:0] {
        WD_IDLE = 2'b00,
        WD_WAIT = 2'b01,
        WD_RST = 2'b10
    } rpc_wd_e;
    typedef logic [21:0] rpc_dly_t;
endpackage : rpc_pkg
`default_nettype wire

/* rtl/rpc_top.sv */
`include "rpc_defs.svh"
`default_nettype none
// Behaviour
// - Clock output follows low three select bits
// - Power-down forces clock output low
// - Watchdog failure holds host reset low
// - Power-down drives host reset low
// - Line power loss raises interrupt
// - Alarm match flagged after source-dependent delay
// - Selected periodic source raises interrupt
// - Interrupt holds until status read
// - Serial input captured MSB first
// - Clock level at select rise sets polarity
// - Serial output shifted MSB first
// - Select low resets serial logic, output off
// - Select toggling services the watchdog
// - Supply enable raised on recovery, interrupt, reset
// - Power-down write drops supply enable
// - Power-on reset clears controls, sets first-up
// - Supply level at reset end picks mode
// - Line select uses line timebase
// - Power-fail sense needs sense on, crystal
// - Supply recovery raises enable, clock, reset
// - Supply loss drops enable, clock, reset
// - Watchdog reset starts two ticks late
// - Status read clears all but sense flag
// - Power-down disables serial interface
module rpc_top
    import rpc_pkg::*;
#(
    parameter rpc_dly_t ALM_CYC_4M = rpc_dly_t'(`RPC_ALM_US_4M * `RPC_CLK_MHZ),
    parameter rpc_dly_t ALM_CYC_2M = rpc_dly_t'(`RPC_ALM_US_2M * `RPC_CLK_MHZ),
    parameter rpc_dly_t ALM_CYC_SLOW = rpc_dly_t'(`RPC_ALM_US_SLOW * `RPC_CLK_MHZ)
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sck,
    input wire logic ss,
    input wire logic mosi,
    output logic miso_o,
    output logic miso_oe,
    input wire logic por_n,
    input wire logic sys_sup_ok,
    input wire logic line_ok,
    input wire logic clk_ctrl_wr,
    input wire logic [7:0] clk_ctrl_wdata,
    output logic [7:0] clk_ctrl_o,
    input wire logic int_ctrl_wr,
    input wire logic [7:0] int_ctrl_wdata,
    output logic [7:0] int_ctrl_o,
    input wire logic stat_rd,
    output logic [7:0] stat_o,
    input wire logic [7:0] clk_src,
    input wire logic [15:0] per_pulse,
    input wire logic alarm_match,
    input wire logic wd_tick,
    input wire logic [7:0] tx_data,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic tb_line_o,
    output logic batt_mode_o,
    output logic bufclk_o,
    output logic host_reset_output_o,
    output logic host_reset_output_oe,
    output logic int_o,
    output logic int_oe,
    output logic supply_enable_output
);
    // ****************************************
    // Reset and pin synchronisers
    // ****************************************
    logic [1:0] rst_sync_reg;
    logic rst_s_n;
    logic [6:0] sy1_reg;
    logic [6:0] sy2_reg;
    logic tgp_reg;
    logic tgn_reg;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_s_n = rst_sync_reg[1];
    always_ff @(posedge core_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            sy1_reg <= 7'h10;
            sy2_reg <= 7'h10;
        end else begin
            sy1_reg <= {tgn_reg, tgp_reg, por_n, line_ok, sys_sup_ok, sck, ss};
            sy2_reg <= sy1_reg;
        end
    end
    logic ss_s, sup_s, line_s, por_s;
    logic [6:0] prev_reg;
    assign ss_s = sy2_reg[0];
    assign sup_s = sy2_reg[2];
    assign line_s = sy2_reg[3];
    assign por_s = sy2_reg[4];
    always_ff @(posedge core_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            prev_reg <= 7'h10;
        end else begin
            prev_reg <= sy2_reg;
        end
    end
    logic ss_edge, sup_rise, line_fall, por_rise, por_clr;
    assign ss_edge = ss_s ^ prev_reg[0];
    assign sup_rise = sup_s & ~prev_reg[2];
    assign line_fall = ~line_s & prev_reg[3];
    assign por_rise = por_s & ~prev_reg[4];
    assign por_clr = ~por_s;
    // ****************************************
    // Control registers
    // ****************************************
    logic [7:0] clk_ctrl_reg;
    logic [7:0] int_ctrl_reg;
    logic [7:0] stat_reg;
    rpc_pwr_e pwr_reg;
    logic wake;
    always_ff @(posedge core_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            clk_ctrl_reg <= `RPC_CTRL_RST;
            int_ctrl_reg <= `RPC_CTRL_RST;
        end else if (por_clr) begin
            clk_ctrl_reg <= `RPC_CTRL_RST;
            int_ctrl_reg <= `RPC_CTRL_RST;
        end else begin
            if (clk_ctrl_wr) begin
                clk_ctrl_reg <= clk_ctrl_wdata;
            end
            if (int_ctrl_wr) begin
                int_ctrl_reg <= int_ctrl_wdata;
            end else if (wake) begin
                int_ctrl_reg[`RPC_IC_PWRDN] <= 1'b0;
            end
        end
    end
    assign clk_ctrl_o = clk_ctrl_reg;
    assign int_ctrl_o = int_ctrl_reg;
    assign tb_line_o = clk_ctrl_reg[`RPC_CC_LINE];
    // ****************************************
    // Event sources
    // ****************************************
    logic [3:0] psel;
    logic per_fire, pf_evt, alm_fire, any_evt, wd_det;
    rpc_dly_t alm_cnt_reg;
    assign psel = int_ctrl_reg[`RPC_IC_PSEL_MSB:`RPC_IC_PSEL_LSB];
    assign per_fire = (psel != 4'h0) & per_pulse[psel];
    assign pf_evt = int_ctrl_reg[`RPC_IC_PSENSE] & ~clk_ctrl_reg[`RPC_CC_LINE]
        & line_fall;
    function automatic rpc_dly_t alm_delay(input logic [1:0] xs);
        case (xs)
            2'h0: alm_delay = ALM_CYC_4M;
            2'h1: alm_delay = ALM_CYC_2M;
            default: alm_delay = ALM_CYC_SLOW;
        endcase
    endfunction : alm_delay
    // Match starts the delay only when idle; a match during the wait is absorbed
    always_ff @(posedge core_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            alm_cnt_reg <= '0;
        end else if (por_clr || !int_ctrl_reg[`RPC_IC_ALARM]) begin
            alm_cnt_reg <= '0;
        end else if (alarm_match && alm_cnt_reg == '0) begin
            alm_cnt_reg <= alm_delay(clk_ctrl_reg[`RPC_CC_XSEL_MSB:`RPC_CC_XSEL_LSB]);
        end else if (alm_cnt_reg != '0) begin
            alm_cnt_reg <= alm_cnt_reg - 1'b1;
        end
    end
    assign alm_fire = (alm_cnt_reg == rpc_dly_t'(1));
    assign any_evt = per_fire | pf_evt | alm_fire;
    // ****************************************
    // Status register
    // ****************************************
    logic [7:0] set_vec;
    assign set_vec = {1'b0, wd_det, 2'b00, any_evt, pf_evt, alm_fire, per_fire};
    // Set beats the read-clear in the same cycle
    always_ff @(posedge core_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            stat_reg <= `RPC_STAT_RST;
        end else if (por_clr) begin
            stat_reg <= `RPC_STAT_RST;
        end else begin
            stat_reg <= (stat_rd ? (stat_reg & `RPC_STAT_KEEP) : stat_reg) | set_vec;
        end
    end
    assign stat_o = stat_reg;
    assign int_o = 1'b0;
    assign int_oe = stat_reg[`RPC_ST_INT];
    // ****************************************
    // Watchdog
    // ****************************************
    rpc_wd_e wd_reg;
    logic [1:0] wd_cnt_reg;
    always_ff @(posedge core_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            wd_reg <= WD_IDLE;
            wd_cnt_reg <= 2'h0;
        end else if (por_clr) begin
            wd_reg <= WD_IDLE;
            wd_cnt_reg <= 2'h0;
        end else begin
            case (wd_reg)
                WD_IDLE: begin
                    if (!int_ctrl_reg[`RPC_IC_WDOG] || ss_edge) begin
                        wd_cnt_reg <= 2'h0;
                    end else if (wd_tick) begin
                        if (wd_cnt_reg == 2'(`RPC_WD_SVC_TICKS - 1)) begin
                            wd_reg <= WD_WAIT;
                            wd_cnt_reg <= 2'h0;
                        end else begin
                            wd_cnt_reg <= wd_cnt_reg + 2'h1;
                        end
                    end
                end
                WD_WAIT: begin
                    if (wd_tick) begin
                        if (wd_cnt_reg == 2'(`RPC_WD_DLY_TICKS - 1)) begin
                            wd_reg <= WD_RST;
                            wd_cnt_reg <= 2'h0;
                        end else begin
                            wd_cnt_reg <= wd_cnt_reg + 2'h1;
                        end
                    end
                end
                WD_RST: begin
                    // Length scales with the timebase tick rate
                    if (wd_tick) begin
                        if (wd_cnt_reg == 2'(`RPC_WD_RST_TICKS - 1)) begin
                            wd_reg <= WD_IDLE;
                            wd_cnt_reg <= 2'h0;
                        end else begin
                            wd_cnt_reg <= wd_cnt_reg + 2'h1;
                        end
                    end
                end
                default: begin
                    wd_reg <= WD_IDLE;
                    wd_cnt_reg <= 2'h0;
                end
            endcase
        end
    end
    assign wd_det = (wd_reg == WD_IDLE) & int_ctrl_reg[`RPC_IC_WDOG] & ~ss_edge
        & wd_tick & (wd_cnt_reg == 2'(`RPC_WD_SVC_TICKS - 1));
    // ****************************************
    // Power sequencing
    // ****************************************
    logic batt_mode_reg;
    assign wake = (pwr_reg == PWR_DOWN) & sup_s & any_evt;
    always_ff @(posedge core_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            pwr_reg <= PWR_OFF;
            batt_mode_reg <= 1'b0;
        end else if (por_clr) begin
            pwr_reg <= PWR_OFF;
        end else if (por_rise) begin
            batt_mode_reg <= ~sup_s;
            pwr_reg <= sup_s ? PWR_ON : PWR_OFF;
        end else begin
            case (pwr_reg)
                PWR_ON: begin
                    if (!sup_s) begin
                        pwr_reg <= PWR_OFF;
                    end else if (int_ctrl_reg[`RPC_IC_PWRDN]) begin
                        pwr_reg <= PWR_DOWN;
                    end
                end
                PWR_OFF: begin
                    if (sup_rise) begin
                        pwr_reg <= PWR_ON;
                    end
                end
                PWR_DOWN: begin
                    if (!sup_s) begin
                        pwr_reg <= PWR_OFF;
                    end else if (wake) begin
                        pwr_reg <= PWR_ON;
                    end
                end
                default: begin
                    pwr_reg <= PWR_OFF;
                end
            endcase
        end
    end
    assign batt_mode_o = batt_mode_reg;
    // ****************************************
    // Pin outputs
    // ****************************************
    logic bufclk_reg, hrst_reg, ser_en_reg;
    logic [2:0] osel;
    assign osel = clk_ctrl_reg[`RPC_CC_OUT_MSB:`RPC_CC_OUT_LSB];
    always_ff @(posedge core_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            bufclk_reg <= 1'b0;
            hrst_reg <= 1'b1;
            ser_en_reg <= 1'b0;
        end else begin
            // Duty cycle is that of the selected source
            bufclk_reg <= (pwr_reg == PWR_ON) & (osel != `RPC_OUT_OFF) & clk_src[osel];
            hrst_reg <= (pwr_reg != PWR_ON) | (wd_reg == WD_RST);
            ser_en_reg <= (pwr_reg == PWR_ON);
        end
    end
    assign bufclk_o = bufclk_reg;
    assign host_reset_output_o = 1'b0;
    assign host_reset_output_oe = hrst_reg;
    assign supply_enable_output = (pwr_reg == PWR_ON);
    // ****************************************
    // Serial link, on its own clock
    // ****************************************
    logic lnk_rst_n, pol_reg;
    logic [2:0] bitp_reg, bitn_reg, bitc;
    logic [6:0] shp_reg, shn_reg;
    logic [7:0] rxp_reg, rxn_reg;
    assign lnk_rst_n = ss & ser_en_reg;
    always_ff @(posedge ss or negedge rst_s_n) begin
        if (!rst_s_n) begin
            pol_reg <= 1'b0;
        end else begin
            pol_reg <= sck;
        end
    end
    always_ff @(posedge sck or negedge lnk_rst_n) begin
        if (!lnk_rst_n) begin
            bitp_reg <= 3'h0;
            shp_reg <= 7'h00;
        end else if (!pol_reg) begin
            bitp_reg <= bitp_reg + 3'h1;
            shp_reg <= {shp_reg[5:0], mosi};
        end
    end
    always_ff @(negedge sck or negedge lnk_rst_n) begin
        if (!lnk_rst_n) begin
            bitn_reg <= 3'h0;
            shn_reg <= 7'h00;
        end else if (pol_reg) begin
            bitn_reg <= bitn_reg + 3'h1;
            shn_reg <= {shn_reg[5:0], mosi};
        end
    end
    // Byte holders survive select going low so the core can fetch them
    always_ff @(posedge sck or negedge rst_s_n) begin
        if (!rst_s_n) begin
            rxp_reg <= 8'h00;
            tgp_reg <= 1'b0;
        end else if (lnk_rst_n && !pol_reg && bitp_reg == 3'h7) begin
            rxp_reg <= {shp_reg, mosi};
            tgp_reg <= ~tgp_reg;
        end
    end
    always_ff @(negedge sck or negedge rst_s_n) begin
        if (!rst_s_n) begin
            rxn_reg <= 8'h00;
            tgn_reg <= 1'b0;
        end else if (lnk_rst_n && pol_reg && bitn_reg == 3'h7) begin
            rxn_reg <= {shn_reg, mosi};
            tgn_reg <= ~tgn_reg;
        end
    end
    // Host must keep tx_data steady for the whole byte
    assign bitc = pol_reg ? bitn_reg : bitp_reg;
    assign miso_o = tx_data[3'h7 - bitc];
    assign miso_oe = ss & ser_en_reg;
    logic rx_valid_reg;
    logic [7:0] rx_data_reg;
    always_ff @(posedge core_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            rx_valid_reg <= 1'b0;
            rx_data_reg <= 8'h00;
        end else begin
            rx_valid_reg <= (sy2_reg[5] ^ prev_reg[5]) | (sy2_reg[6] ^ prev_reg[6]);
            if (sy2_reg[5] ^ prev_reg[5]) begin
                rx_data_reg <= rxp_reg;
            end else if (sy2_reg[6] ^ prev_reg[6]) begin
                rx_data_reg <= rxn_reg;
            end
        end
    end
    assign rx_valid = rx_valid_reg;
    assign rx_data = rx_data_reg;
    // ****************************************
    // Checks
    // ****************************************
    sequence s_pwrdn_req;
        pwr_reg == PWR_ON && sup_s && int_ctrl_reg[`RPC_IC_PWRDN] && !por_clr && !por_rise;
    endsequence
    sequence s_all_low;
        !supply_enable_output ##1 host_reset_output_oe && !bufclk_reg;
    endsequence
    a_pwrdn_outputs: assert property (@(posedge core_clk) disable iff (!rst_s_n)
        s_pwrdn_req |=> s_all_low) else $error("power-down outputs wrong");
    a_bufclk_low: assert property (@(posedge core_clk) disable iff (!rst_s_n)
        pwr_reg != PWR_ON |=> !bufclk_reg) else $error("clock out not low");
    a_int_hold: assert property (@(posedge core_clk) disable iff (!rst_s_n)
        int_oe && !stat_rd && !por_clr |=> int_oe) else $error("interrupt dropped");
    a_rd_clear: assert property (@(posedge core_clk) disable iff (!rst_s_n)
        stat_rd && !any_evt && !wd_det && por_s |=> stat_reg[3:0] == ($past(stat_reg[3:0])
        & 4'h4)) else $error("status read clear wrong");
    a_pfail_int: assert property (@(posedge core_clk) disable iff (!rst_s_n)
        pf_evt && por_s |=> int_oe && stat_reg[`RPC_ST_PFAIL]) else $error("power fail lost");
    a_alarm_count: assert property (@(posedge core_clk) disable iff (!rst_s_n)
        alm_cnt_reg > rpc_dly_t'(1) && int_ctrl_reg[`RPC_IC_ALARM] && por_s
        |=> alm_cnt_reg == $past(alm_cnt_reg) - 1'b1) else $error("alarm delay stalls");
    a_wd_late: assert property (@(posedge core_clk) disable iff (!rst_s_n)
        wd_det |=> wd_reg == WD_WAIT ##1 !host_reset_output_oe || pwr_reg != PWR_ON)
        else $error("watchdog reset too early");
    a_wd_reset: assert property (@(posedge core_clk) disable iff (!rst_s_n)
        wd_reg == WD_RST |=> host_reset_output_oe) else $error("host reset not low");
    a_serial_off: assert property (@(posedge core_clk) disable iff (!rst_s_n)
        pwr_reg != PWR_ON |=> !miso_oe) else $error("serial not disabled");
endmodule : rpc_top
`default_nettype wire

/* rtl/rpc_pkg_unused_marker.sv */
`default_nettype none
`default_nettype wire

/* tb/rpc_host.sv */
`default_nettype none
// ****
// Host serial master
// ****
module rpc_host (
    output logic sck,
    output logic ss,
    output logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic last = 1'b0;
    logic miso_w;
    // Released line shows inverse of last bit, never a stale copy
    assign miso_w = miso_oe ? miso_o : ~last;
    initial begin
        sck = 1'b0;
        ss = 1'b0;
        mosi = 1'b0;
    end
    // Sck changes outside frames only to take the idle level before select rises
    task automatic xfer(input logic cpol, input logic [7:0] tx, output logic [7:0] rx);
        sck = cpol;
        #20 ss = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            #16 rx[i] = miso_w;
            last = miso_w;
            sck = ~cpol;
            #16 sck = cpol;
        end
        #16 ss = 1'b0;
        mosi = ~mosi;
    endtask : xfer
    task automatic toggle_ss();
        #20 ss = 1'b1;
        #48 ss = 1'b0;
    endtask : toggle_ss
    task automatic sel(input logic v);
        ss = v;
    endtask : sel
endmodule : rpc_host
`default_nettype wire

/* tb/tb_top.sv */
`default_nettype none
`define CHK(n, x, g) \
    begin \
        comparisons++; \
        if ((g) !== (x)) begin \
            mismatches++; \
            $display("Error %s expected %h seen %h", n, x, g); \
        end \
    end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // ****
    // Signals
    // ****
    logic core_clk = 0, rst_n = 0, por_n = 0, sys_sup_ok = 1, line_ok = 1;
    logic clk_ctrl_wr = 0, int_ctrl_wr = 0, stat_rd = 0, alarm_match = 0, wd_tick = 0;
    logic [7:0] clk_ctrl_wdata = 0, int_ctrl_wdata = 0, clk_src = 0, tx_data = 0;
    logic [15:0] per_pulse = 0;
    logic sck, ss, mosi, miso_o, miso_oe, rx_valid, tb_line_o, batt_mode_o;
    logic bufclk_o, hr_o, hr_oe, int_o, int_oe, sup_en;
    logic [7:0] clk_ctrl_o, int_ctrl_o, stat_o, rx_data, b, r, e, q;
    logic [7:0] exp_q[$];
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    int d;
    rpc_top #(.ALM_CYC_4M(22'd20), .ALM_CYC_2M(22'd40), .ALM_CYC_SLOW(22'd80)) i_rpc_top (
        .core_clk(core_clk), .rst_n(rst_n), .sck(sck), .ss(ss), .mosi(mosi),
        .miso_o(miso_o), .miso_oe(miso_oe), .por_n(por_n), .sys_sup_ok(sys_sup_ok),
        .line_ok(line_ok), .clk_ctrl_wr(clk_ctrl_wr), .clk_ctrl_wdata(clk_ctrl_wdata),
        .clk_ctrl_o(clk_ctrl_o), .int_ctrl_wr(int_ctrl_wr),
        .int_ctrl_wdata(int_ctrl_wdata), .int_ctrl_o(int_ctrl_o), .stat_rd(stat_rd),
        .stat_o(stat_o), .clk_src(clk_src), .per_pulse(per_pulse),
        .alarm_match(alarm_match), .wd_tick(wd_tick), .tx_data(tx_data),
        .rx_data(rx_data), .rx_valid(rx_valid), .tb_line_o(tb_line_o),
        .batt_mode_o(batt_mode_o), .bufclk_o(bufclk_o), .host_reset_output_o(hr_o),
        .host_reset_output_oe(hr_oe), .int_o(int_o), .int_oe(int_oe),
        .supply_enable_output(sup_en));
    rpc_host i_rpc_host (.sck(sck), .ss(ss), .mosi(mosi), .miso_o(miso_o),
        .miso_oe(miso_oe));
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
        if (rx_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                `CHK("rx_valid", 1'b0, rx_valid)
            end else begin
                q = exp_q.pop_front();
                `CHK("rx_data", q, rx_data)
            end
        end
    end
    // ****
    // Tasks
    // ****
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc
    task automatic wr(input logic ic, input logic [7:0] v);
        clk_ctrl_wdata = v;
        int_ctrl_wdata = v;
        clk_ctrl_wr = !ic;
        int_ctrl_wr = ic;
        cyc(1);
        clk_ctrl_wr = 0;
        int_ctrl_wr = 0;
        // Strobe low across one edge so back-to-back writes never re-drive it at once
        cyc(1);
    endtask : wr
    task automatic rd_stat();
        stat_rd = 1;
        cyc(1);
        stat_rd = 0;
        cyc(2);
    endtask : rd_stat
    task automatic tick();
        wd_tick = 1;
        cyc(1);
        wd_tick = 0;
        cyc(9);
    endtask : tick
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test
    // ****
    // Scenarios
    // ****
    initial begin
        void'($urandom(32'h0d16376f));
        cyc(3);
        rst_n = 1;
        cyc(3);
        por_n = 1;
        cyc(6);
        `CHK("stat", 8'h10, stat_o)
        `CHK("ctrl", 16'h0000, {clk_ctrl_o, int_ctrl_o})
        `CHK("sup_batt_rst", 3'h4, {sup_en, batt_mode_o, hr_oe})
        `CHK("od_low", 2'b00, {int_o, hr_o})
        $display("test reset done");
        clk_src = $urandom();
        for (int k = 0; k < 8; k++) begin
            wr(0, k[7:0]);
            cyc(3);
            `CHK("bufclk", (k == 4) ? 1'b0 : clk_src[k], bufclk_o)
            clk_src = ~clk_src;
            cyc(3);
            `CHK("bufclk", (k == 4) ? 1'b0 : clk_src[k], bufclk_o)
        end
        wr(0, 8'h40);
        cyc(2);
        `CHK("line_sel", 1'b1, tb_line_o)
        wr(0, 8'h00);
        $display("test clock out done");
        for (int i = 0; i < 6; i++) begin
            tx_data = $urandom();
            b = $urandom();
            exp_q.push_back(b);
            i_rpc_host.xfer(i[0], b, r);
            `CHK("miso", tx_data, r)
            cyc(8);
            `CHK("rx_pending", 0, exp_q.size())
            `CHK("miso_oe", 1'b0, miso_oe)
        end
        $display("test serial done");
        for (int i = 0; i < 4; i++) begin
            e = 8'h01 + 8'($urandom() % 15);
            wr(1, e);
            per_pulse = ~(16'h0001 << e[3:0]);
            cyc(1);
            per_pulse = 0;
            cyc(3);
            `CHK("int_other", 1'b0, int_oe)
            per_pulse = 16'h0001 << e[3:0];
            cyc(1);
            per_pulse = 0;
            cyc(2);
            `CHK("stat_per", 4'h9, {stat_o[3:0]})
            cyc(5);
            `CHK("int_hold", 1'b1, int_oe)
            rd_stat();
            `CHK("stat_rd", 9'h000, {int_oe, stat_o})
        end
        $display("test periodic done");
        for (int x = 0; x < 4; x++) begin
            d = (x == 0) ? 20 : (x == 1) ? 40 : 80;
            wr(0, 8'(x << 4));
            wr(1, 8'h10);
            alarm_match = 1;
            cyc(1);
            alarm_match = 0;
            cyc(d - 4);
            `CHK("alarm_early", 2'b00, {int_oe, stat_o[1]})
            cyc(8);
            `CHK("alarm", 2'b11, {int_oe, stat_o[1]})
            rd_stat();
        end
        wr(0, 8'h40);
        wr(1, 8'h20);
        line_ok = 0;
        cyc(8);
        `CHK("sense_line", 1'b0, int_oe)
        line_ok = 1;
        wr(0, 8'h00);
        wr(1, 8'h00);
        wr(1, 8'h20);
        cyc(6);
        line_ok = 0;
        cyc(8);
        `CHK("sense", 3'h7, {int_oe, stat_o[3:2]})
        rd_stat();
        `CHK("sense_keep", 8'h04, stat_o)
        wr(1, 8'h00);
        line_ok = 1;
        $display("test alarm and sense done");
        clk_src = 8'hff;
        wr(1, 8'h41);
        cyc(4);
        `CHK("pdown", 3'h1, {sup_en, bufclk_o, hr_oe})
        i_rpc_host.sel(1);
        cyc(3);
        `CHK("pdown_miso", 1'b0, miso_oe)
        i_rpc_host.sel(0);
        cyc(20);
        `CHK("pdown_hold", 1'b0, sup_en)
        per_pulse = 16'h0002;
        cyc(1);
        per_pulse = 0;
        cyc(6);
        `CHK("wake", 2'b10, {sup_en, hr_oe})
        rd_stat();
        wr(1, 8'h00);
        sys_sup_ok = 0;
        cyc(8);
        `CHK("sup_low", 3'h1, {sup_en, bufclk_o, hr_oe})
        sys_sup_ok = 1;
        cyc(8);
        `CHK("sup_up", 3'h6, {sup_en, bufclk_o, hr_oe})
        $display("test power done");
        wr(1, 8'h80);
        repeat (6) begin
            tick();
            i_rpc_host.toggle_ss();
            // Let the synced select edge pass so the next tick is not swallowed
            cyc(4);
        end
        `CHK("wd_served", 2'b00, {stat_o[6], hr_oe})
        tick();
        tick();
        `CHK("wd_flag", 2'b10, {stat_o[6], hr_oe})
        tick();
        `CHK("wd_late", 1'b0, hr_oe)
        tick();
        `CHK("wd_rst", 1'b1, hr_oe)
        tick();
        `CHK("wd_hold", 1'b1, hr_oe)
        tick();
        tick();
        `CHK("wd_end", 1'b0, hr_oe)
        wr(1, 8'h00);
        rd_stat();
        wr(1, 8'h2f);
        por_n = 0;
        sys_sup_ok = 0;
        cyc(5);
        `CHK("por_mid", 24'h000010, {clk_ctrl_o, int_ctrl_o, stat_o})
        por_n = 1;
        cyc(5);
        `CHK("por_batt", 2'b01, {sup_en, batt_mode_o})
        sys_sup_ok = 1;
        cyc(8);
        `CHK("sup_batt", 3'h6, {sup_en, batt_mode_o, hr_oe})
        $display("test watchdog and por done");
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
